// ===== design/lbr_rx_status.v
/*
 * Receive side of a serial controller with break-field handling and
 * gathering of status sources into one status interrupt.
 * Assumes line inputs already synchronous to clk and a transmitter
 * that reports its bit phases with one-cycle pulses.
 */
// Function
// - Normal mode detects break only while awaiting
// - Normal-mode good break raises receive-complete
// - Awaiting clear: judge errors at stop, store
// - Normal awaiting set: no errors, no store
// - Normal awaiting clear: consistency error timing
// - Normal awaiting set: consistency error timing
// - Break-success flag never set in normal mode
// - Break mode detects break during data too
// - Low stop defers judgement until line high
// - Short low: report error, store first byte
// - Long low: set break-success, store nothing
// - Break mode awaiting set: no errors, no store
// - Break mode awaiting clear: consistency timing
// - Awaiting set: high during break timing
// - Any source raises status interrupt and flag
// - Flags clear by writing one; busy exempt
// - Parity and framing error conditions
// - Overrun when both buffer entries still unread
// - Consistency error on mismatch or step loss
// - Auto-baud ID parity, checksum, response errors
// - Extension-bit detect and ID match conditions
// - Break length counted falling to rising edge
// - Awaiting flag set by trigger, cleared by break
`timescale 1ns/1ps
`default_nettype none
`include "lbr_consts.vh"

module lbr_rx_status
(
  input  wire                 clk,
  input  wire                 sys_rst,
  input  wire [7:0]           baud_div,
  input  wire                 op_mode_hi,
  input  wire                 op_mode_lo,
  input  wire                 consistency_check_en,
  input  wire                 parity_en,
  input  wire                 parity_odd,
  input  wire                 ext_bit_en,
  input  wire                 ext_compare_en,
  input  wire                 ext_level_sel,
  input  wire [7:0]           id_compare_reg,
  input  wire                 break_receive_trigger,
  input  wire [`LBR_ST_W-1:0] status_clear_reg,
  input  wire                 auto_id_parity_err,
  input  wire                 auto_checksum_err,
  input  wire                 auto_resp_prep_err,
  input  wire                 rx_in,
  input  wire                 tx_active,
  input  wire                 tx_bit,
  input  wire                 tx_break,
  input  wire                 tx_stop_start,
  input  wire                 tx_next_start,
  input  wire                 rx_data_ready,
  output wire [7:0]           rx_data_reg,
  output wire                 rx_data_valid,
  output reg  [`LBR_ST_W-1:0] status_reg,
  output reg                  status_irq,
  output reg                  rx_complete_irq,
  output reg                  awaiting_break_flag,
  output reg                  tx_busy_flag,
  output reg                  rx_busy_flag
);

  // ****************************************************************
  // Tick divider and line edge
  // ****************************************************************
  reg  [7:0] div_cnt;
  reg        tick;
  reg        rx_q;
  wire       rx_rise = rx_in & ~rx_q;
  wire       rx_fall = ~rx_in & rx_q;
  wire       brk_mode = op_mode_hi;
  wire       auto_mode = op_mode_hi & op_mode_lo;

  // One-cycle enable every baud_div+1 clocks, sixteen per bit
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      div_cnt <= `LBR_DIV_RST;
      tick    <= 1'b0;
      rx_q    <= 1'b1;
    end
    else
    begin
      tick    <= (div_cnt == baud_div);
      div_cnt <= (div_cnt == baud_div) ? 8'h00 : div_cnt + 8'h01;
      rx_q    <= rx_in;
    end
  end

  // ****************************************************************
  // Receiver state
  // ****************************************************************
  reg  [2:0] state;
  reg  [3:0] tck;
  reg  [3:0] bitn;
  reg  [9:0] sh;
  reg  [8:0] lowcnt;
  reg        lowrun;
  wire       sample = tick & (tck == `LBR_SAMPLE);
  wire [3:0] nbits = 4'h8 + {3'h0, ext_bit_en} + {3'h0, parity_en};
  wire       long_low = (lowcnt >= `LBR_BREAK_TICKS);
  wire       par_rx = ext_bit_en ? sh[9] : sh[8];
  wire       par_bad = parity_en & ((^sh[7:0]) ^ par_rx ^ parity_odd);
  wire       buf_ready;

  reg  [2:0] next_state;
  reg        ev_store;
  reg        ev_judge;
  reg        ev_fe;
  reg        ev_bsf;
  reg        ev_brk_ok;

  // Next state and frame-end events
  always @*
  begin
    next_state = state;
    ev_store   = 1'b0;
    ev_judge   = 1'b0;
    ev_fe      = 1'b0;
    ev_bsf     = 1'b0;
    ev_brk_ok  = 1'b0;
    case (state)
      `LBR_S_IDLE:
        if (rx_fall)
          next_state = awaiting_break_flag ? `LBR_S_BREAK
                                           : `LBR_S_START;
      `LBR_S_START:
        if (sample)
          next_state = rx_in ? `LBR_S_IDLE : `LBR_S_DATA;
      `LBR_S_DATA:
        if (sample && (bitn == nbits - 4'h1))
          next_state = `LBR_S_STOP;
      `LBR_S_STOP:
        if (sample)
        begin
          if (rx_in)
          begin
            ev_judge   = 1'b1;
            next_state = `LBR_S_IDLE;
          end
          else if (brk_mode)
            next_state = `LBR_S_WAITHI;
          else
          begin
            ev_judge   = 1'b1;
            ev_fe      = 1'b1;
            next_state = `LBR_S_IDLE;
          end
        end
      `LBR_S_WAITHI:
        if (rx_in)
        begin
          next_state = `LBR_S_IDLE;
          if (long_low)
            ev_bsf = 1'b1;
          else
          begin
            ev_judge = 1'b1;
            ev_fe    = 1'b1;
          end
        end
      `LBR_S_BREAK:
        // No judging or storing while awaiting a break
        if (rx_in)
        begin
          next_state = `LBR_S_IDLE;
          ev_brk_ok  = long_low;
        end
      default:
        next_state = `LBR_S_IDLE;
    endcase
    ev_store = ev_judge & buf_ready;
  end

  // Shift in data bits and measure the low period from the falling edge
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      state  <= `LBR_S_IDLE;
      tck    <= 4'h0;
      bitn   <= 4'h0;
      sh     <= 10'h000;
      lowcnt <= 9'h000;
      lowrun <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (state == `LBR_S_IDLE)
      begin
        tck  <= 4'h0;
        bitn <= 4'h0;
      end
      else if (tick)
        tck <= tck + 4'h1;
      if (sample && state == `LBR_S_DATA)
      begin
        sh[bitn] <= rx_in;
        bitn     <= bitn + 4'h1;
      end
      if (rx_fall && state == `LBR_S_IDLE)
      begin
        lowcnt <= 9'h000;
        lowrun <= 1'b1;
      end
      else if (rx_in)
        lowrun <= 1'b0;
      else if (tick && lowrun && !long_low)
        lowcnt <= lowcnt + 9'h001;
    end
  end

  // ****************************************************************
  // Consistency check against the transmitter
  // ****************************************************************
  reg  dce_pend;
  reg  stop_seen;
  reg  run_at_stop;
  reg  hi_in_brk;
  wire rx_run = (state != `LBR_S_IDLE);
  wire dce_fire = dce_pend & (
         (tx_next_start & ~run_at_stop)
       | (~brk_mode & ~awaiting_break_flag & tx_stop_start & rx_run)
       | (~brk_mode & awaiting_break_flag & run_at_stop
          & stop_seen & rx_rise)
       | (brk_mode & ~awaiting_break_flag & run_at_stop
          & stop_seen & sample & rx_in)
       | (brk_mode & awaiting_break_flag & hi_in_brk
          & tx_next_start)
       | (brk_mode & awaiting_break_flag & ~hi_in_brk
          & run_at_stop & stop_seen & sample & rx_in));

  // Mismatch or early end is held until the mode's firing point
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      dce_pend    <= 1'b0;
      stop_seen   <= 1'b0;
      run_at_stop <= 1'b0;
      hi_in_brk   <= 1'b0;
    end
    else
    begin
      if (dce_fire)
        dce_pend <= 1'b0;
      else if (consistency_check_en & tx_active & ~stop_seen
               & ((sample & (rx_in != tx_bit))
                  | (state == `LBR_S_STOP & sample)))
        dce_pend <= 1'b1;
      if (tx_stop_start)
      begin
        stop_seen   <= 1'b1;
        run_at_stop <= rx_run;
      end
      else if (dce_fire | (~tx_active & ~dce_pend))
        stop_seen <= 1'b0;
      if (tx_break & rx_in)
        hi_in_brk <= 1'b1;
      else if (~tx_active & ~dce_pend)
        hi_in_brk <= 1'b0;
    end
  end

  // ****************************************************************
  // Status flags, interrupts and awaiting-break flag
  // ****************************************************************
  wire [`LBR_ST_W-1:0] set_vec;
  wire                 ovr = ev_judge & ~buf_ready;
  wire                 word_ok = ev_judge & ~ev_fe;

  assign set_vec[`LBR_ST_PE]  = ev_judge & par_bad;
  assign set_vec[`LBR_ST_FE]  = ev_fe;
  assign set_vec[`LBR_ST_OVE] = ovr;
  assign set_vec[`LBR_ST_DCE] = dce_fire;
  assign set_vec[`LBR_ST_BSF] = brk_mode
                                & (ev_bsf | ev_brk_ok);
  assign set_vec[`LBR_ST_IPE] = auto_mode & auto_id_parity_err;
  assign set_vec[`LBR_ST_CSE] = auto_mode & auto_checksum_err;
  assign set_vec[`LBR_ST_RPE] = auto_mode & auto_resp_prep_err;
  assign set_vec[`LBR_ST_IDM] = word_ok & ext_bit_en & ext_compare_en
                                & (sh[8] == ext_level_sel)
                                & (sh[7:0] == id_compare_reg);
  assign set_vec[`LBR_ST_EBD] = word_ok & ext_bit_en
                                & (sh[8] == ext_level_sel);

  // Set wins over a clear in the same cycle so no event is lost
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      status_reg          <= `LBR_ST_RST;
      status_irq          <= 1'b0;
      rx_complete_irq     <= 1'b0;
      awaiting_break_flag <= 1'b0;
      tx_busy_flag        <= 1'b0;
      rx_busy_flag        <= 1'b0;
    end
    else
    begin
      status_reg <= (status_reg & ~status_clear_reg) | set_vec;
      status_irq <= |set_vec;
      // Clean word, or a good break in normal mode
      rx_complete_irq <= (ev_store & ~(|set_vec))
                         | (~brk_mode & ev_brk_ok);
      if (break_receive_trigger)
        awaiting_break_flag <= 1'b1;
      else if (ev_brk_ok)
        awaiting_break_flag <= 1'b0;
      // Busy bits follow activity and ignore clear writes
      tx_busy_flag <= tx_active;
      rx_busy_flag <= next_state != `LBR_S_IDLE;
    end
  end

  // ****************************************************************
  // Receive data path
  // ****************************************************************
  // Overrun drops the new word; the older unread one is kept
  lbr_rx_buf u_buf
  (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_data   (sh[7:0]),
    .in_valid  (ev_store),
    .in_ready  (buf_ready),
    .out_data  (rx_data_reg),
    .out_valid (rx_data_valid),
    .out_ready (rx_data_ready)
  );

endmodule // lbr_rx_status

`default_nettype wire

// ===== design/lbr_consts.vh
/*
 * Constants for the break-field aware serial receiver: mode codes,
 * status bit positions, bit timing and receiver state codes.
 * Assumes inclusion by bare name from design files only.
 */
`ifndef LBR_CONSTS_VH
`define LBR_CONSTS_VH

// ****************************************************************
// Operating modes (op_mode_hi, op_mode_lo)
// ****************************************************************
`define LBR_MODE_NORMAL 2'h0
`define LBR_MODE_BRKCOM 2'h2
`define LBR_MODE_AUTO   2'h3

// ****************************************************************
// Status register bit positions
// ****************************************************************
`define LBR_ST_PE   0
`define LBR_ST_FE   1
`define LBR_ST_OVE  2
`define LBR_ST_DCE  3
`define LBR_ST_BSF  4
`define LBR_ST_IPE  5
`define LBR_ST_CSE  6
`define LBR_ST_RPE  7
`define LBR_ST_IDM  8
`define LBR_ST_EBD  9
`define LBR_ST_W    10
`define LBR_ST_RST  10'h000

// ****************************************************************
// Bit timing: 16 ticks per bit, sample in the middle
// ****************************************************************
`define LBR_OVS        5'h10
`define LBR_SAMPLE     4'h7
`define LBR_BREAK_BITS 11
`define LBR_BREAK_TICKS (`LBR_BREAK_BITS * 16)
`define LBR_DIV_RST    8'h00

// ****************************************************************
// Receiver states
// ****************************************************************
`define LBR_S_IDLE   3'h0
`define LBR_S_START  3'h1
`define LBR_S_DATA   3'h2
`define LBR_S_STOP   3'h3
`define LBR_S_WAITHI 3'h4
`define LBR_S_BREAK  3'h5

`endif

// ===== design/lbr_rx_buf.v
/*
 * Two-entry receive buffer with valid/ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module lbr_rx_buf
(
  input  wire       clk,
  input  wire       sys_rst,
  input  wire [7:0] in_data,
  input  wire       in_valid,
  output wire       in_ready,
  output reg  [7:0] out_data,
  output reg        out_valid,
  input  wire       out_ready
);

  reg  [7:0] spare;
  reg        spare_v;
  wire       pop;

  // Full only when both slots hold a word
  assign in_ready = ~spare_v;
  assign pop      = out_valid & out_ready;

  // Head feeds the port directly; spare catches a word during a stall
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      out_data  <= 8'h00;
      out_valid <= 1'b0;
      spare     <= 8'h00;
      spare_v   <= 1'b0;
    end
    else
    begin
      if (pop | ~out_valid)
      begin
        if (spare_v)
        begin
          out_data  <= spare;
          out_valid <= 1'b1;
          spare_v   <= in_valid;
          spare     <= in_data;
        end
        else
        begin
          out_data  <= in_data;
          out_valid <= in_valid;
        end
      end
      else if (in_valid & ~spare_v)
      begin
        spare   <= in_data;
        spare_v <= 1'b1;
      end
    end
  end

endmodule // lbr_rx_buf

`default_nettype wire

// ===== dv/lbr_rx_status_properties.sv
/* Port checker for the break-aware receiver, bound from the bench.
   Assumes one clock and the synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none

module lbr_rx_status_properties
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       op_mode_hi,
  input wire logic       op_mode_lo,
  input wire logic       consistency_check_en,
  input wire logic       break_receive_trigger,
  input wire logic [9:0] status_clear_reg,
  input wire logic       auto_checksum_err,
  input wire logic       rx_data_ready,
  input wire logic [7:0] rx_data_reg,
  input wire logic       rx_data_valid,
  input wire logic [9:0] status_reg,
  input wire logic       status_irq,
  input wire logic       rx_complete_irq,
  input wire logic       awaiting_break_flag
);
  // ****************
  // Properties
  // ****************
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_BSF_NORMAL: assert property (
    !op_mode_hi && !op_mode_lo |=> !$rose(status_reg[4]))
    else $error("break flag set in normal mode");
  AST_CLEAR: assert property (
    status_clear_reg[1] |=> !status_reg[1] || status_irq)
    else $error("flag survived its clear");
  AST_STICKY: assert property (
    $fell(status_reg[0]) |-> $past(status_clear_reg[0]))
    else $error("flag fell without a clear");
  AST_IRQ_SRC: assert property (
    |(status_reg & ~$past(status_reg)) |-> status_irq)
    else $error("new flag without status interrupt");
  AST_AUTO_ONLY: assert property (
    $rose(status_reg[6]) |-> $past(op_mode_hi && op_mode_lo))
    else $error("checksum flag outside auto mode");
  AST_AUTO_CSE: assert property (
    op_mode_hi && op_mode_lo && auto_checksum_err
    |=> status_reg[6] && status_irq)
    else $error("checksum error not flagged");
  AST_TRIG: assert property (
    break_receive_trigger |=> awaiting_break_flag)
    else $error("trigger did not arm break wait");
  AST_BRK_NORMAL: assert property (
    $fell(awaiting_break_flag) && !op_mode_hi
    |-> rx_complete_irq && !status_irq)
    else $error("normal break gave wrong interrupt");
  AST_BRK_COMM: assert property (
    $fell(awaiting_break_flag) && op_mode_hi
    |-> status_irq && status_reg[4])
    else $error("break in comm mode not flagged");
  // Buffer head must not move while the reader stalls
  AST_HOLD: assert property (
    rx_data_valid && !rx_data_ready
    |=> rx_data_valid && $stable(rx_data_reg))
    else $error("receive word lost during stall");
  AST_DCE_EN: assert property (
    $rose(status_reg[3]) |-> $past(consistency_check_en))
    else $error("consistency flag while check off");
endmodule // lbr_rx_status_properties

`default_nettype wire

// ===== dv/lbr_line_node.sv
/* Far node on the serial line: sends bit strings, LSB first.
   Assumes baud_div of zero, so one bit lasts 16 clocks. */
`timescale 1ns/1ps
`default_nettype none

module lbr_line_node
(
  input  wire logic clk,
  output var  logic line
);
  // ****************
  // Line driver
  // ****************
  // Idle line rests high, as its pull-up would leave it
  initial line = 1'h1;

  // Each bit changes just after an edge and holds 16 clocks
  task automatic send(input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk) line <= v[i];
      repeat (15) @(posedge clk);
    end
    @(posedge clk) line <= 1'h1;
  endtask
endmodule // lbr_line_node

`default_nettype wire

// ===== dv/lbr_rx_status_tb_top.sv
/* Bench for the break-aware receiver: expected-word queue vs design.
   Assumes baud_div of zero and the line node as far party. */
`timescale 1ns/1ps
`default_nettype none

module lbr_rx_status_tb_top;
  logic clk = 1'h0, sys_rst = 1'h1, rx_in;
  logic op_mode_hi = 1'h0, op_mode_lo = 1'h0, parity_en = 1'h0;
  logic parity_odd = 1'h0, ext_bit_en = 1'h0, ext_compare_en = 1'h0;
  logic ext_level_sel = 1'h0, break_receive_trigger = 1'h0;
  logic consistency_check_en = 1'h0, auto_id_parity_err = 1'h0;
  logic auto_checksum_err = 1'h0, auto_resp_prep_err = 1'h0;
  logic tx_active = 1'h0, tx_bit = 1'h1, tx_break = 1'h0;
  logic tx_stop_start = 1'h0, tx_next_start = 1'h0, rx_data_ready = 1'h0;
  logic [7:0] baud_div = 8'h00, id_compare_reg = 8'h00, rx_data_reg, d;
  logic [9:0] status_clear_reg = 10'h000, status_reg;
  logic rx_data_valid, status_irq, rx_complete_irq, awaiting_break_flag;
  logic tx_busy_flag, rx_busy_flag;
  logic [7:0] exp_q[$];
  int fails = 0, check_count = 0, irq_n = 0;

  // 10 MHz clock
  always #50 clk = ~clk;

  // Count receive-complete pulses; a one-cycle pulse is easy to miss
  always @(posedge clk)
    if (rx_complete_irq === 1'h1)
      irq_n++;

  lbr_rx_status i_lbr_rx_status (.*);
  lbr_line_node i_lbr_line_node (.clk(clk), .line(rx_in));

  // ****************
  // Helpers
  // ****************
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Ends off the edge so later reads see settled values
  task automatic idle(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic clr();
    @(posedge clk) status_clear_reg <= 10'h3FF;
    @(posedge clk) status_clear_reg <= 10'h000;
    idle(2);
    chk("status_reg", 0, status_reg);
  endtask

  task automatic arm();
    @(posedge clk) break_receive_trigger <= 1'h1;
    @(posedge clk) break_receive_trigger <= 1'h0;
    idle(2);
    chk("awaiting", 1, awaiting_break_flag);
  endtask

  // Random reader stalls; ready drops with the last expected word
  task automatic drain();
    int n = 0;
    while (exp_q.size() > 0 && n < 500)
    begin
      @(negedge clk) n++;
      if (rx_data_valid === 1'h1 && rx_data_ready === 1'h1)
        chk("rx_data_reg", exp_q.pop_front(), rx_data_reg);
      @(posedge clk) rx_data_ready <= exp_q.size() > 0 && 1'($urandom);
    end
    idle(3);
    chk("words_left", 0, exp_q.size());
    chk("rx_data_valid", 0, rx_data_valid);
  endtask

  task automatic wrap_up();
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ****************
  // Scenarios
  // ****************
  initial
  begin
    void'($urandom(13641));
    repeat (12) @(posedge clk);
    sys_rst <= 1'h0;
    idle(2);
    // Three words, no reader: the third overruns the buffer
    for (int i = 0; i < 3; i++)
    begin
      d = 8'($urandom);
      if (i < 2)
        exp_q.push_back(d);
      i_lbr_line_node.send({1'h1, d, 1'h0}, 10);
    end
    idle(4);
    chk("overrun", 1, status_reg[2]);
    chk("rx_complete_irq", 2, irq_n);
    drain();
    clr();
    // Low stop bit, then odd parity with a wrong parity bit
    exp_q.push_back(d);
    i_lbr_line_node.send({1'h0, d, 1'h0}, 10);
    idle(4);
    chk("framing", 1, status_reg[1]);
    clr();
    parity_en <= 1'h1;
    parity_odd <= 1'h1;
    exp_q.push_back(d);
    i_lbr_line_node.send({1'h1, ^d, d, 1'h0}, 11);
    idle(4);
    chk("parity", 1, status_reg[0]);
    drain();
    clr();
    // Extension bit at the selected level, byte equal to compare value
    parity_en <= 1'h0;
    ext_bit_en <= 1'h1;
    ext_compare_en <= 1'h1;
    ext_level_sel <= 1'h1;
    id_compare_reg <= d;
    exp_q.push_back(d);
    i_lbr_line_node.send({2'h3, d, 1'h0}, 11);
    idle(4);
    chk("ext_match", 2'h3, status_reg[9:8]);
    drain();
    clr();
    // Normal mode waiting for a break: data ignored, break accepted
    ext_bit_en <= 1'h0;
    arm();
    i_lbr_line_node.send({1'h1, 8'h55, 1'h0}, 10);
    i_lbr_line_node.send(16'h0000, 12);
    idle(8);
    chk("awaiting", 0, awaiting_break_flag);
    chk("rx_complete_irq", 3, irq_n);
    chk("status_reg", 0, status_reg);
    drain();
    // Break mode: long low is a break, short low is a framing error
    op_mode_hi <= 1'h1;
    consistency_check_en <= 1'h1;
    i_lbr_line_node.send(16'h0000, 12);
    idle(8);
    chk("break_ok", 1, status_reg[4]);
    clr();
    exp_q.push_back(8'h00);
    i_lbr_line_node.send(16'h0000, 10);
    idle(8);
    chk("status_reg", 10'h002, status_reg);
    drain();
    clr();
    // Own break sent while waiting for one
    arm();
    tx_active <= 1'h1;
    tx_break <= 1'h1;
    tx_bit <= 1'h0;
    i_lbr_line_node.send(16'h0000, 12);
    chk("tx_busy_flag", 1, tx_busy_flag);
    chk("rx_busy_flag", 1, rx_busy_flag);
    tx_break <= 1'h0;
    tx_active <= 1'h0;
    tx_bit <= 1'h1;
    idle(8);
    chk("break_ok", 1, status_reg[4]);
    chk("awaiting", 0, awaiting_break_flag);
    drain();
    clr();
    // Sent high while line low: flagged only with the check enabled
    for (int k = 1; k >= 0; k--)
    begin
      op_mode_hi <= 1'h0;
      consistency_check_en <= 1'(k);
      tx_active <= 1'h1;
      exp_q.push_back(8'h00);
      i_lbr_line_node.send({1'h1, 8'h00, 1'h0}, 10);
      tx_stop_start <= 1'h1;
      @(posedge clk) tx_stop_start <= 1'h0;
      tx_next_start <= 1'h1;
      @(posedge clk) tx_next_start <= 1'h0;
      tx_active <= 1'h0;
      idle(4);
      chk("consistency", k, status_reg[3]);
      drain();
      clr();
    end
    // Auto-baud error pulses count only in auto mode
    for (int k = 0; k < 2; k++)
    begin
      {op_mode_hi, op_mode_lo} <= {2{1'(k)}};
      @(posedge clk);
      {auto_id_parity_err, auto_checksum_err, auto_resp_prep_err} <= 3'h7;
      @(posedge clk);
      {auto_id_parity_err, auto_checksum_err, auto_resp_prep_err} <= 3'h0;
      idle(2);
      chk("auto_errs", {3{1'(k)}}, status_reg[7:5]);
      clr();
    end
    wrap_up();
  end

  // Watchdog well beyond the expected run of some 2500 clocks
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    wrap_up();
  end
endmodule // lbr_rx_status_tb_top

bind lbr_rx_status lbr_rx_status_properties i_props (.*);

`default_nettype wire
